// ==== logic/boundary_scan_tap_port.sv ====
// test access port controller with a data path into a buffered output stream
`timescale 1ns/100ps

// ----------------------------------------
// synchronous fifo
// ----------------------------------------
module stream_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fill side
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	// drain side
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wrPtr_r;
	logic [AW:0] rdPtr_r;
	logic full;
	logic empty;

	assign empty = (wrPtr_r == rdPtr_r);
	assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
	assign inReady = !full;
	assign outValid = !empty;
	assign outData = mem[rdPtr_r[AW-1:0]];

	always_ff @(posedge clk) begin
		if (inValid && !full) begin
			mem[wrPtr_r[AW-1:0]] <= inData;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr_r <= '0;
		end else if (inValid && !full) begin
			wrPtr_r <= wrPtr_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdPtr_r <= '0;
		end else if (outReady && !empty) begin
			rdPtr_r <= rdPtr_r + 1'b1;
		end
	end
endmodule // stream_fifo

// ----------------------------------------
// test access port
// ----------------------------------------
// Contract
// RQ1: standard test port pins, boundary-scan behaviour
// RQ2: data input captured on rising test clock
// RQ3: mode select sampled rising, steers controller
// RQ4: data output driven only in shift states
// RQ5: data output changes on falling edges only
// RQ6: test reset initialises controller without clock
// RQ7: tester asserts test reset after power-up
// RQ8: five high mode selects reach reset
module boundary_scan_tap_port
	import tap_port_pkg::*;
#(
	parameter int DATA_W = DATA_W_DEFAULT,
	parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT,
	parameter logic [ID_W-1:0] ID_WORD = ID_DEFAULT
) (
	// system clock and reset
	input wire logic clk,
	input wire logic rst,
	// test port
	input wire logic tck,
	input wire logic tmsIn,
	input wire logic tdiIn,
	input wire logic trstN,
	output logic tdoOut,
	output logic tdoEn,
	// received word stream
	output logic [DATA_W-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	// tck domain
	tap_state_t state_r;
	tap_state_t state_nxt;
	logic [IR_W-1:0] ir_r;
	logic [IR_W-1:0] irShift_r;
	logic [ID_W-1:0] drShift_r;
	logic [DATA_W-1:0] dataHold_r;
	logic reqLvl_r;
	logic accept;
	logic ackSync1_r;
	logic ackSync2_r;
	logic tdo_r;
	logic tdoEn_r;
	logic busy;
	// clk domain
	logic reqSync1_r;
	logic reqSync2_r;
	logic reqSync3_r;
	logic pending_r;
	logic ackLvl_r;
	logic [DATA_W-1:0] outData_r;
	logic outValid_r;
	logic fifoInReady;
	logic [DATA_W-1:0] fifoOutData;
	logic fifoOutValid;
	logic takeOut;
	logic push;

	// level handshake: a test reset in mid-transfer cannot fake a request
	assign busy = reqLvl_r || ackSync2_r;
	assign accept = (state_r == UPDATE_DR) && (ir_r == INS_DATAWR) && !busy;

	// ----------------------------------------
	// controller state machine
	// ----------------------------------------
	// RQ3 mode select steering
	always_comb begin
		case (state_r)
			TEST_RESET: state_nxt = tmsIn ? TEST_RESET : RUN_IDLE;
			RUN_IDLE: state_nxt = tmsIn ? SELECT_DR : RUN_IDLE;
			SELECT_DR: state_nxt = tmsIn ? SELECT_IR : CAPTURE_DR;
			CAPTURE_DR: state_nxt = tmsIn ? EXIT1_DR : SHIFT_DR;
			SHIFT_DR: state_nxt = tmsIn ? EXIT1_DR : SHIFT_DR;
			EXIT1_DR: state_nxt = tmsIn ? UPDATE_DR : PAUSE_DR;
			PAUSE_DR: state_nxt = tmsIn ? EXIT2_DR : PAUSE_DR;
			EXIT2_DR: state_nxt = tmsIn ? UPDATE_DR : SHIFT_DR;
			UPDATE_DR: state_nxt = tmsIn ? SELECT_DR : RUN_IDLE;
			// RQ8 high from here returns to reset
			SELECT_IR: state_nxt = tmsIn ? TEST_RESET : CAPTURE_IR;
			CAPTURE_IR: state_nxt = tmsIn ? EXIT1_IR : SHIFT_IR;
			SHIFT_IR: state_nxt = tmsIn ? EXIT1_IR : SHIFT_IR;
			EXIT1_IR: state_nxt = tmsIn ? UPDATE_IR : PAUSE_IR;
			PAUSE_IR: state_nxt = tmsIn ? EXIT2_IR : PAUSE_IR;
			EXIT2_IR: state_nxt = tmsIn ? UPDATE_IR : SHIFT_IR;
			UPDATE_IR: state_nxt = tmsIn ? SELECT_DR : RUN_IDLE;
			default: state_nxt = TEST_RESET;
		endcase
	end

	// RQ6 asynchronous controller reset
	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			state_r <= TEST_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------
	// instruction register
	// ----------------------------------------
	// RQ2 instruction bits from data input
	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			irShift_r <= IR_CAPTURE;
		end else if (state_r == CAPTURE_IR) begin
			irShift_r <= IR_CAPTURE;
		end else if (state_r == SHIFT_IR) begin
			irShift_r <= {tdiIn, irShift_r[IR_W-1:1]};
		end
	end

	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			ir_r <= IR_RESET;
		end else if (state_r == TEST_RESET) begin
			ir_r <= IR_RESET;
		end else if (state_r == UPDATE_IR) begin
			ir_r <= irShift_r;
		end
	end

	// ----------------------------------------
	// data registers
	// ----------------------------------------
	// RQ2 data bits from data input
	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			drShift_r <= '0;
		end else if (state_r == CAPTURE_DR) begin
			case (ir_r)
				INS_IDCODE: drShift_r <= ID_WORD;
				INS_DATAWR: drShift_r <= {{(ID_W-1){1'b0}}, busy};
				default: drShift_r <= '0;
			endcase
		end else if (state_r == SHIFT_DR) begin
			case (ir_r)
				INS_IDCODE: drShift_r <= {tdiIn, drShift_r[ID_W-1:1]};
				INS_DATAWR: drShift_r[DATA_W-1:0] <= {tdiIn, drShift_r[DATA_W-1:1]};
				default: drShift_r[0] <= tdiIn;
			endcase
		end
	end

	// RQ1 update hands word to system side
	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			reqLvl_r <= 1'b0;
		end else if (accept) begin
			reqLvl_r <= 1'b1;
		end else if (ackSync2_r) begin
			reqLvl_r <= 1'b0;
		end
	end

	// no test reset here: a word already flagged to the system side stays intact
	always_ff @(posedge tck) begin
		if (accept) begin
			dataHold_r <= drShift_r[DATA_W-1:0];
		end
	end

	always_ff @(posedge tck or negedge trstN) begin
		if (!trstN) begin
			ackSync1_r <= 1'b0;
			ackSync2_r <= 1'b0;
		end else begin
			ackSync1_r <= ackLvl_r;
			ackSync2_r <= ackSync1_r;
		end
	end

	// ----------------------------------------
	// test data output
	// ----------------------------------------
	// RQ5 falling edge update, RQ4 enable in shift
	always_ff @(negedge tck or negedge trstN) begin
		if (!trstN) begin
			tdo_r <= 1'b0;
			tdoEn_r <= 1'b0;
		end else begin
			tdo_r <= (state_r == SHIFT_IR) ? irShift_r[0] : drShift_r[0];
			tdoEn_r <= (state_r == SHIFT_IR) || (state_r == SHIFT_DR);
		end
	end

	assign tdoOut = tdo_r;
	assign tdoEn = tdoEn_r;

	// ----------------------------------------
	// system side crossing
	// ----------------------------------------
	assign push = pending_r && fifoInReady;

	always_ff @(posedge clk) begin
		if (rst) begin
			reqSync1_r <= 1'b0;
			reqSync2_r <= 1'b0;
			reqSync3_r <= 1'b0;
		end else begin
			reqSync1_r <= reqLvl_r;
			reqSync2_r <= reqSync1_r;
			reqSync3_r <= reqSync2_r;
		end
	end

	// word is held stable until acknowledged
	always_ff @(posedge clk) begin
		if (rst) begin
			pending_r <= 1'b0;
		end else if (reqSync2_r && !reqSync3_r) begin
			pending_r <= 1'b1;
		end else if (push) begin
			pending_r <= 1'b0;
		end
	end

	// acknowledge stays up until the request has dropped
	always_ff @(posedge clk) begin
		if (rst) begin
			ackLvl_r <= 1'b0;
		end else if (push) begin
			ackLvl_r <= 1'b1;
		end else if (!reqSync2_r) begin
			ackLvl_r <= 1'b0;
		end
	end

	stream_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) fifoInst (
		.clk(clk),
		.rst(rst),
		.inData(dataHold_r),
		.inValid(pending_r),
		.inReady(fifoInReady),
		.outData(fifoOutData),
		.outValid(fifoOutValid),
		.outReady(takeOut)
	);

	// ----------------------------------------
	// output register stage
	// ----------------------------------------
	assign takeOut = !outValid_r || outReady;

	always_ff @(posedge clk) begin
		if (rst) begin
			outValid_r <= 1'b0;
			outData_r <= '0;
		end else if (takeOut) begin
			outValid_r <= fifoOutValid;
			outData_r <= fifoOutData;
		end
	end

	assign outData = outData_r;
	assign outValid = outValid_r;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_RESET_STATE: assert property (@(posedge tck) !trstN |-> state_r == TEST_RESET) // RQ6
		else $error("controller not in reset while test reset low");
	AST_TMS_FIVE: assert property (@(posedge tck) disable iff (!trstN) // RQ8
		tmsIn [*5] |=> state_r == TEST_RESET)
		else $error("five high mode selects did not reach reset");
	AST_IDLE_STEP: assert property (@(posedge tck) disable iff (!trstN) // RQ3
		state_r == RUN_IDLE |=> state_r == ($past(tmsIn) ? SELECT_DR : RUN_IDLE))
		else $error("idle state did not follow mode select");
	AST_DRIVE_SHIFT: assert property (@(posedge tck) disable iff (!trstN) // RQ4
		tdoEn == (state_r == SHIFT_IR || state_r == SHIFT_DR))
		else $error("data output enable outside shift states");
	AST_TDO_FALL: assert property (@(posedge tck) disable iff (!trstN) // RQ5
		state_r == SHIFT_DR && $past(state_r) == SHIFT_DR |-> tdoOut == drShift_r[0])
		else $error("data output not set from shifter at falling edge");
	AST_TDI_DR: assert property (@(posedge tck) disable iff (!trstN) // RQ2
		state_r == SHIFT_DR && ir_r == INS_BYPASS |=> drShift_r[0] == $past(tdiIn))
		else $error("bypass bit did not capture data input");
	AST_TDI_IR: assert property (@(posedge tck) disable iff (!trstN) // RQ2
		state_r == SHIFT_IR |=> irShift_r[IR_W-1] == $past(tdiIn))
		else $error("instruction shifter did not capture data input");
	AST_UPDATE_REQ: assert property (@(posedge tck) disable iff (!trstN) // RQ1
		state_r == UPDATE_DR && ir_r == INS_DATAWR && !busy |=> busy && $rose(reqLvl_r))
		else $error("data update did not raise a request");
	AST_PUSH_ONCE: assert property (@(posedge clk) disable iff (rst) // RQ1
		push |=> !pending_r && ackLvl_r)
		else $error("pending word not cleared after push");
	COV_IDCODE: cover property (@(posedge tck) disable iff (!trstN)
		state_r == CAPTURE_DR && ir_r == INS_IDCODE);
	COV_DATAWR: cover property (@(posedge tck) disable iff (!trstN)
		state_r == UPDATE_DR && ir_r == INS_DATAWR && !busy);
	COV_FULL: cover property (@(posedge clk) disable iff (rst) pending_r && !fifoInReady);
endmodule // boundary_scan_tap_port

// ==== logic/tap_port_pkg.sv ====
// constants, instruction codes and controller states of the test access port
package tap_port_pkg;

	// ----------------------------------------
	// instruction register
	// ----------------------------------------
	localparam int IR_W = 4;
	localparam logic [IR_W-1:0] INS_DATAWR = 4'h8;
	localparam logic [IR_W-1:0] INS_IDCODE = 4'h2;
	localparam logic [IR_W-1:0] INS_BYPASS = 4'hf;
	// value loaded into the instruction shifter on capture, low bits 01
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
	// instruction selected after reset
	localparam logic [IR_W-1:0] IR_RESET = INS_IDCODE;

	// ----------------------------------------
	// data registers
	// ----------------------------------------
	localparam int ID_W = 32;
	// identification word, arbitrary value, bit 0 must stay set
	localparam logic [ID_W-1:0] ID_DEFAULT = 32'h0000_a001;
	localparam int DATA_W_DEFAULT = 8;
	localparam int FIFO_DEPTH_DEFAULT = 8;

	// ----------------------------------------
	// controller states
	// ----------------------------------------
	typedef enum logic [3:0] {
		EXIT2_DR = 4'b0000,
		EXIT1_DR = 4'b0001,
		SHIFT_DR = 4'b0010,
		PAUSE_DR = 4'b0011,
		SELECT_IR = 4'b0100,
		UPDATE_DR = 4'b0101,
		CAPTURE_DR = 4'b0110,
		SELECT_DR = 4'b0111,
		EXIT2_IR = 4'b1000,
		EXIT1_IR = 4'b1001,
		SHIFT_IR = 4'b1010,
		PAUSE_IR = 4'b1011,
		RUN_IDLE = 4'b1100,
		UPDATE_IR = 4'b1101,
		CAPTURE_IR = 4'b1110,
		TEST_RESET = 4'b1111
	} tap_state_t;

endpackage

// ==== tb/tap_tester.sv ====
// behavioural test controller driving the test port
`timescale 1ns/100ps
module tap_tester (
	// test port
	output logic tck,
	output logic tmsIn,
	output logic tdiIn,
	output logic trstN,
	input wire logic tdoOut,
	input wire logic tdoEn
);
	logic tdoPrev;
	logic tdoLine;
	// released line shows a toggling level
	assign tdoLine = (tdoEn === 1'b1) ? tdoOut : ~tdoPrev;
	initial begin
		tck = 1'b0;
		tmsIn = 1'b1;
		tdiIn = 1'b1;
		// pulled up until the tester resets the port
		trstN = 1'b1;
		tdoPrev = 1'b0;
	end
	always @(posedge tck) begin
		tdoPrev <= tdoLine;
	end
	task automatic setReset(input logic v);
		trstN <= v;
	endtask
	// one clock, inputs set while the clock is low, output sampled at the rise
	task automatic step(input logic t, input logic d, output logic q);
		tmsIn <= t;
		tdiIn <= d;
		#40;
		q = tdoLine;
		tck <= 1'b1;
		#40;
		tck <= 1'b0;
	endtask
	task automatic idle(input int n);
		logic q;
		for (int i = 0; i < n; i++) begin
			step(1'b0, 1'b1, q);
		end
	endtask
	task automatic pulseReset();
		trstN <= 1'b0;
		idle(2);
		trstN <= 1'b1;
		#20;
		idle(1);
	endtask
	// from run-idle back to run-idle, lsb first
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
			output logic [31:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b1, q);
		if (ir) begin
			step(1'b1, 1'b1, q);
		end
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask
endmodule // tap_tester

// ==== tb/tb.sv ====
// testbench of the test access port and its word stream
`timescale 1ns/100ps
module tb;
	import tap_port_pkg::*;
	localparam int CAP = FIFO_DEPTH_DEFAULT + 2;
	logic clk;
	logic rst;
	logic outReady;
	logic outValid;
	logic [DATA_W_DEFAULT-1:0] outData;
	logic tck;
	logic tmsIn;
	logic tdiIn;
	logic trstN;
	logic tdoOut;
	logic tdoEn;
	logic q;
	logic [7:0] rnd;
	logic [7:0] rdyRnd;
	logic [31:0] dout;
	int readyMode;
	int nErrors;
	int nCompared;
	logic [DATA_W_DEFAULT-1:0] expQ[$];

	boundary_scan_tap_port #(.DATA_W(DATA_W_DEFAULT), .FIFO_DEPTH(FIFO_DEPTH_DEFAULT),
			.ID_WORD(ID_DEFAULT)) boundary_scan_tap_port_i (.clk(clk), .rst(rst), .tck(tck),
			.tmsIn(tmsIn), .tdiIn(tdiIn), .trstN(trstN), .tdoOut(tdoOut), .tdoEn(tdoEn),
			.outData(outData), .outValid(outValid), .outReady(outReady));
	tap_tester tap_tester_i (.tck(tck), .tmsIn(tmsIn), .tdiIn(tdiIn), .trstN(trstN),
			.tdoOut(tdoOut), .tdoEn(tdoEn));

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic chkScan(input string name, input logic [31:0] e, input logic [31:0] g);
		nCompared++;
		if (g !== e) begin
			nErrors++;
			$display("Error %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic chkWord(input string name, input logic [DATA_W_DEFAULT-1:0] e,
			input logic [DATA_W_DEFAULT-1:0] g);
		nCompared++;
		if (g !== e) begin
			nErrors++;
			$display("Error %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic finishTest();
		if (nErrors == 0 && nCompared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic writeWords(input int n);
		logic [31:0] d;
		for (int i = 0; i < n; i++) begin
			tap_tester_i.idle(8);
			rnd = lfsr(rnd);
			tap_tester_i.scan(1'b0, DATA_W_DEFAULT, {24'h0, rnd}, d);
			chkScan("busy", {31'h0, expQ.size() >= CAP}, d);
			if (expQ.size() < CAP) begin
				expQ.push_back(rnd);
			end
		end
	endtask
	task automatic drain();
		for (int t = 0; t < 2000 && expQ.size() > 0; t++) begin
			@(posedge clk);
		end
		if (expQ.size() > 0) begin
			nErrors++;
			$display("Error drain expected 0 seen %0d", expQ.size());
			finishTest();
		end
		repeat (20) @(posedge clk);
	endtask

	always #25 clk = ~clk;
	always @(posedge clk) begin
		rdyRnd <= lfsr(rdyRnd);
		outReady <= (readyMode == 1) || (readyMode == 2 && rdyRnd[0]);
		if (rst === 1'b0 && outValid === 1'b1 && outReady === 1'b1) begin
			chkWord("outData", (expQ.size() > 0) ? expQ.pop_front() : ~outData, outData);
		end
	end
	always @(tdoOut or tdoEn) begin
		if (trstN === 1'b1 && tck !== 1'b0) begin
			chkScan("tdoEdge", 32'h0, 32'h1);
		end
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		outReady = 1'b0;
		readyMode = 0;
		rnd = 8'h53;
		rdyRnd = 8'h53;
		nErrors = 0;
		nCompared = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		tap_tester_i.pulseReset();
		tap_tester_i.scan(1'b0, ID_W, 32'h0, dout);
		chkScan("idWord", ID_DEFAULT, dout);
		#10;
		chkScan("tdoEnIdle", 32'h0, {31'h0, tdoEn});
		tap_tester_i.scan(1'b1, IR_W, {28'h0, INS_DATAWR}, dout);
		chkScan("irCapture", {28'h0, IR_CAPTURE}, dout);
		writeWords(CAP + 2);
		readyMode = 2;
		drain();
		readyMode = 1;
		writeWords(3);
		drain();
		// abandon a data shift with five high mode selects
		// passing update-dr hands over capture zeros shifted by 0 then 1
		expQ.push_back(8'h80);
		tap_tester_i.step(1'b1, 1'b1, q);
		tap_tester_i.step(1'b0, 1'b1, q);
		tap_tester_i.step(1'b0, 1'b0, q);
		tap_tester_i.step(1'b0, 1'b0, q);
		repeat (5) tap_tester_i.step(1'b1, 1'b1, q);
		tap_tester_i.idle(1);
		tap_tester_i.scan(1'b0, ID_W, 32'h0, dout);
		chkScan("idAfterTms", ID_DEFAULT, dout);
		// stop the clock in instruction shift, then reset without a clock edge
		tap_tester_i.step(1'b1, 1'b1, q);
		tap_tester_i.step(1'b1, 1'b1, q);
		tap_tester_i.step(1'b0, 1'b1, q);
		tap_tester_i.step(1'b0, 1'b1, q);
		#10;
		chkScan("tdoEnShift", 32'h1, {31'h0, tdoEn});
		tap_tester_i.setReset(1'b0);
		#10;
		chkScan("tdoEnReset", 32'h0, {31'h0, tdoEn});
		tap_tester_i.setReset(1'b1);
		#10;
		tap_tester_i.idle(1);
		tap_tester_i.scan(1'b0, ID_W, 32'h0, dout);
		chkScan("idAfterReset", ID_DEFAULT, dout);
		// one-bit bypass path: captured zero leads the data
		tap_tester_i.scan(1'b1, IR_W, {28'h0, INS_BYPASS}, dout);
		chkScan("irBypass", {28'h0, IR_CAPTURE}, dout);
		rnd = lfsr(rnd);
		tap_tester_i.scan(1'b0, DATA_W_DEFAULT, {24'h0, rnd}, dout);
		chkScan("bypass", {24'h0, rnd[6:0], 1'b0}, dout);
		drain();
		finishTest();
	end
endmodule // tb
